// File: core/bpt_bridge_option_regs.sv
// port options, retry limit and master timeout control of a bridge
//
// Function
// - wi alias 0 sends a plain write, 1 disconnects at lines, reset 0.
// - long-request bit asks long requests in lock cycles.
// - sec hold 0 drops request at frame, 1 holds it, reset 1.
// - pri hold 0 drops request at frame, 1 holds it, reset 1.
// - port option bits 15:12 read zero.
// - 32-bit retry limit, reset 0100_0000h.
// - sec timeout initial value in bits 15:0, reset 8000h.
// - pri timeout initial value in bits 31:16, reset 8000h.
// - coarse bits give 1024 or 32768 clocks, last write wins.
// - timeout starts after last data or first line.
// - expiry discards the buffered data.
// - slot slot_ident_capability_code reads 04h.
`timescale 1ns/100ps
`default_nettype none
module bpt_bridge_option_regs
   import bpt_pkg::*;
(
   input  wire logic              i_clock,
   input  wire logic              i_arst_n,
   // register port
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [DATA_W-1:0] i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic      [DATA_W-1:0] o_rdata,
   // secondary write-and-invalidate path
   input  wire logic              i_sec_write_and_invalidate_cmd,
   input  wire logic              i_sec_line_boundary,
   output logic                   o_sec_plain_memory_write_cmd,
   output logic                   o_sec_wi_disconnect,
   // lock
   input  wire logic              i_lock_active,
   output logic                   o_lock_long_req,
   // internal masters, secondary then primary
   input  wire logic              i_sec_queue_pending,
   input  wire logic              i_sec_frame,
   input  wire logic              i_sec_target_term,
   input  wire logic              i_sec_xfer_done,
   output logic                   o_sec_req,
   input  wire logic              i_pri_queue_pending,
   input  wire logic              i_pri_frame,
   input  wire logic              i_pri_target_term,
   input  wire logic              i_pri_xfer_done,
   output logic                   o_pri_req,
   // delayed read completion per side
   input  wire logic              i_sec_rd_short,
   input  wire logic              i_sec_rd_last_data,
   input  wire logic              i_sec_rd_first_line,
   input  wire logic              i_sec_rd_retrieved,
   output logic                   o_sec_discard,
   input  wire logic              i_pri_rd_short,
   input  wire logic              i_pri_rd_last_data,
   input  wire logic              i_pri_rd_first_line,
   input  wire logic              i_pri_rd_retrieved,
   output logic                   o_pri_discard,
   // retry attempts
   input  wire logic              i_retry_attempt,
   input  wire logic              i_retry_success,
   output logic                   o_retry_timeout,
   // interrupt
   output logic                   o_irq
);
   //////////////////////////////////////////////////////////////////////
   // decode helper
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] off);
      return a == off;
   endfunction

   logic              wr_option;
   logic              wr_retry;
   logic              wr_tmo;
   logic              wr_coarse;
   logic              wr_slot;
   assign wr_option = i_wr & hit(i_addr, OFF_PORT_OPTION);
   assign wr_retry  = i_wr & hit(i_addr, OFF_RETRY_LIMIT);
   assign wr_tmo    = i_wr & hit(i_addr, OFF_MASTER_TMO);
   assign wr_coarse = i_wr & hit(i_addr, OFF_COARSE_CTRL);
   assign wr_slot   = i_wr & hit(i_addr, OFF_SLOT_IDENT);

   //////////////////////////////////////////////////////////////////////
   // option bits 11:8; lower byte lives elsewhere
   logic [3:0]        opt_upper_r;
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         opt_upper_r <= PO_UPPER_RST;
      end else if (wr_option) begin
         opt_upper_r <= i_wdata[PO_PRI_HOLD:PO_SEC_WI_ALIAS];
      end
   end

   logic              sec_wi_alias;
   logic              long_req_en;
   logic [1:0]        hold_en;
   assign sec_wi_alias      = opt_upper_r[PO_SEC_WI_ALIAS-PO_SEC_WI_ALIAS];
   assign long_req_en       = opt_upper_r[PO_LONG_REQ-PO_SEC_WI_ALIAS];
   assign hold_en[SIDE_SEC] = opt_upper_r[PO_SEC_HOLD-PO_SEC_WI_ALIAS];
   assign hold_en[SIDE_PRI] = opt_upper_r[PO_PRI_HOLD-PO_SEC_WI_ALIAS];

   //////////////////////////////////////////////////////////////////////
   // write-and-invalidate handling and lock requests
   logic              sec_plain_r;
   logic              sec_disc_r;
   logic              lock_long_r;
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sec_plain_r <= 1'b0;
         sec_disc_r  <= 1'b0;
      end else begin
         sec_plain_r <= i_sec_write_and_invalidate_cmd & ~sec_wi_alias;
         sec_disc_r  <= i_sec_write_and_invalidate_cmd & sec_wi_alias
                        & i_sec_line_boundary;
      end
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         lock_long_r <= 1'b0;
      end else begin
         lock_long_r <= i_lock_active & long_req_en;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // bus request of each internal master
   logic [1:0]        want;
   logic [1:0]        frame;
   logic [1:0]        term;
   logic [1:0]        done;
   logic [1:0]        in_xfer_r;
   logic [1:0]        req_r;
   assign want  = {i_pri_queue_pending, i_sec_queue_pending};
   assign frame = {i_pri_frame, i_sec_frame};
   assign term  = {i_pri_target_term, i_sec_target_term};
   assign done  = {i_pri_xfer_done, i_sec_xfer_done};

   generate
      for (genvar s = 0; s < 2; s++) begin : g_req
         logic busy;
         assign busy = in_xfer_r[s] | frame[s];
         always_ff @(posedge i_clock or negedge i_arst_n) begin
            if (!i_arst_n) begin
               in_xfer_r[s] <= 1'b0;
            end else if (done[s] | term[s]) begin
               in_xfer_r[s] <= 1'b0;
            end else if (frame[s]) begin
               in_xfer_r[s] <= 1'b1;
            end
         end
         // once framed, only a holding master keeps asking
         always_ff @(posedge i_clock or negedge i_arst_n) begin
            if (!i_arst_n) begin
               req_r[s] <= 1'b0;
            end else if (!busy) begin
               req_r[s] <= want[s];
            end else begin
               req_r[s] <= hold_en[s] & want[s] & ~term[s];
            end
         end
      end
   endgenerate

   //////////////////////////////////////////////////////////////////////
   // retry limit and attempt counter
   logic [31:0]       retry_limit_r;
   logic [31:0]       retry_cnt_r;
   logic              retry_tmo_r;
   logic              retry_hit;
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         retry_limit_r <= RETRY_RST;
      end else if (wr_retry) begin
         retry_limit_r <= i_wdata;
      end
   end

   assign retry_hit = i_retry_attempt & (retry_cnt_r + 32'h0000_0001
                      >= retry_limit_r);

   // restarts on success or timeout
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         retry_cnt_r <= '0;
         retry_tmo_r <= 1'b0;
      end else begin
         retry_tmo_r <= retry_hit;
         if (i_retry_success | retry_hit) begin
            retry_cnt_r <= '0;
         end else if (i_retry_attempt) begin
            retry_cnt_r <= retry_cnt_r + 32'h0000_0001;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////
   // timeout initial values, last write wins
   logic [TMO_W-1:0]  fine_r [2];
   logic [1:0]        coarse_r;
   logic [TMO_W-1:0]  init_r [2];
   logic [1:0]        coarse_bit;
   assign coarse_bit = {i_wdata[CO_PRI_BIT], i_wdata[CO_SEC_BIT]};

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         fine_r[SIDE_SEC] <= TMO_RST;
         fine_r[SIDE_PRI] <= TMO_RST;
      end else if (wr_tmo) begin
         fine_r[SIDE_SEC] <= i_wdata[TMO_SEC_LSB +: TMO_W];
         fine_r[SIDE_PRI] <= i_wdata[TMO_PRI_LSB +: TMO_W];
      end
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         coarse_r <= '0;
      end else if (wr_coarse) begin
         coarse_r <= coarse_bit;
      end
   end

   generate
      for (genvar s = 0; s < 2; s++) begin : g_init
         always_ff @(posedge i_clock or negedge i_arst_n) begin
            if (!i_arst_n) begin
               init_r[s] <= TMO_RST;
            end else if (wr_tmo) begin
               init_r[s] <= i_wdata[s*TMO_W +: TMO_W];
            end else if (wr_coarse) begin
               init_r[s] <= coarse_bit[s] ? TMO_COARSE_LONG
                                          : TMO_COARSE_SHORT;
            end
         end
      end
   endgenerate

   //////////////////////////////////////////////////////////////////////
   // master timeout counters
   logic [1:0]        tmo_start;
   logic [1:0]        tmo_stop;
   logic [1:0]        tmo_expire;
   assign tmo_start[SIDE_SEC] = i_sec_rd_short ? i_sec_rd_last_data
                                               : i_sec_rd_first_line;
   assign tmo_start[SIDE_PRI] = i_pri_rd_short ? i_pri_rd_last_data
                                               : i_pri_rd_first_line;
   assign tmo_stop = {i_pri_rd_retrieved, i_sec_rd_retrieved};

   generate
      for (genvar s = 0; s < 2; s++) begin : g_tmo
         bpt_timeout_counter u_cnt (
            .i_clock   (i_clock),
            .i_arst_n  (i_arst_n),
            .i_init    (init_r[s]),
            .i_start   (tmo_start[s]),
            .i_stop    (tmo_stop[s]),
            .o_running (),
            .o_expire  (tmo_expire[s])
         );
      end
   endgenerate

   //////////////////////////////////////////////////////////////////////
   // slot identification fields
   logic [4:0]        slot_num_r;
   logic              slot_first_r;
   logic [7:0]        chassis_r;
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         slot_num_r   <= '0;
         slot_first_r <= 1'b0;
         chassis_r    <= '0;
      end else if (wr_slot) begin
         slot_num_r   <= i_wdata[SLOT_NUM_LSB +: 5];
         slot_first_r <= i_wdata[SLOT_FIRST_BIT];
         chassis_r    <= i_wdata[CHASSIS_LSB +: 8];
      end
   end

   //////////////////////////////////////////////////////////////////////
   // interrupt status, clear and enable
   logic [IRQ_W-1:0]  irq_stat_r;
   logic [IRQ_W-1:0]  irq_en_r;
   logic [IRQ_W-1:0]  irq_evt;
   logic [IRQ_W-1:0]  irq_clr;
   logic              irq_r;
   assign irq_evt = {retry_tmo_r, tmo_expire[SIDE_PRI], tmo_expire[SIDE_SEC]};
   assign irq_clr = (i_wr & hit(i_addr, OFF_IRQ_CLEAR)) ? i_wdata[IRQ_W-1:0]
                                                        : '0;

   // a new event beats a clear in the same cycle
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         irq_stat_r <= '0;
      end else begin
         irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_evt;
      end
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         irq_en_r <= '0;
      end else if (i_wr & hit(i_addr, OFF_IRQ_ENABLE)) begin
         irq_en_r <= i_wdata[IRQ_W-1:0];
      end
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(((irq_stat_r & ~irq_clr) | irq_evt) & irq_en_r);
      end
   end

   //////////////////////////////////////////////////////////////////////
   // read data one cycle after strobe
   logic [DATA_W-1:0] rd_mux;
   logic [DATA_W-1:0] rdata_r;
   always_comb begin
      rd_mux = '0;
      unique case (i_addr)
         OFF_PORT_OPTION: begin
            rd_mux[PO_PRI_HOLD:PO_SEC_WI_ALIAS] = opt_upper_r;
         end
         OFF_RETRY_LIMIT: begin
            rd_mux = retry_limit_r;
         end
         OFF_MASTER_TMO: begin
            rd_mux = {fine_r[SIDE_PRI], fine_r[SIDE_SEC]};
         end
         OFF_COARSE_CTRL: begin
            rd_mux[CO_SEC_BIT] = coarse_r[SIDE_SEC];
            rd_mux[CO_PRI_BIT] = coarse_r[SIDE_PRI];
         end
         OFF_SLOT_IDENT: begin
            rd_mux[7:0]                   = SLOT_CAP_ID;
            rd_mux[SLOT_NUM_LSB +: 5]     = slot_num_r;
            rd_mux[SLOT_FIRST_BIT]        = slot_first_r;
            rd_mux[CHASSIS_LSB +: 8]      = chassis_r;
         end
         OFF_IRQ_STATUS: begin
            rd_mux[IRQ_W-1:0] = irq_stat_r;
         end
         OFF_IRQ_ENABLE: begin
            rd_mux[IRQ_W-1:0] = irq_en_r;
         end
         default: begin
            rd_mux = '0;
         end
      endcase
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rdata_r <= '0;
      end else if (i_rd) begin
         rdata_r <= rd_mux;
      end else begin
         rdata_r <= '0;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // outputs
   assign o_rdata                      = rdata_r;
   assign o_sec_plain_memory_write_cmd = sec_plain_r;
   assign o_sec_wi_disconnect          = sec_disc_r;
   assign o_lock_long_req              = lock_long_r;
   assign o_sec_req                    = req_r[SIDE_SEC];
   assign o_pri_req                    = req_r[SIDE_PRI];
   assign o_sec_discard                = tmo_expire[SIDE_SEC];
   assign o_pri_discard                = tmo_expire[SIDE_PRI];
   assign o_retry_timeout              = retry_tmo_r;
   assign o_irq                        = irq_r;
endmodule
`default_nettype wire

// File: core/bpt_pkg.sv
// constants for the bridge port option and master timeout registers
package bpt_pkg;
   localparam int          ADDR_W           = 8;
   localparam int          DATA_W           = 32;
   localparam int          TMO_W            = 16;
   // register offsets
   localparam logic [7:0]  OFF_COARSE_CTRL  = 8'h3c;
   localparam logic [7:0]  OFF_PORT_OPTION  = 8'h74;
   localparam logic [7:0]  OFF_RETRY_LIMIT  = 8'h78;
   localparam logic [7:0]  OFF_MASTER_TMO   = 8'h80;
   localparam logic [7:0]  OFF_SLOT_IDENT   = 8'hb0;
   localparam logic [7:0]  OFF_IRQ_STATUS   = 8'hc0;
   localparam logic [7:0]  OFF_IRQ_CLEAR    = 8'hc4;
   localparam logic [7:0]  OFF_IRQ_ENABLE   = 8'hc8;
   // port option fields
   localparam int          PO_SEC_WI_ALIAS  = 8;
   localparam int          PO_LONG_REQ      = 9;
   localparam int          PO_SEC_HOLD      = 10;
   localparam int          PO_PRI_HOLD      = 11;
   localparam int          PO_W             = 16;
   localparam logic [3:0]  PO_UPPER_RST     = 4'hc;
   // coarse timeout select bits
   localparam int          CO_PRI_BIT       = 24;
   localparam int          CO_SEC_BIT       = 25;
   localparam logic [15:0] TMO_COARSE_SHORT = 16'h0400;
   localparam logic [15:0] TMO_COARSE_LONG  = 16'h8000;
   localparam logic [15:0] TMO_RST          = 16'h8000;
   localparam int          TMO_SEC_LSB      = 0;
   localparam int          TMO_PRI_LSB      = 16;
   // retry limit
   localparam logic [31:0] RETRY_RST        = 32'h0100_0000;
   // slot identification structure
   localparam logic [7:0]  SLOT_CAP_ID      = 8'h04;
   localparam int          SLOT_NUM_LSB     = 16;
   localparam int          SLOT_FIRST_BIT   = 21;
   localparam int          CHASSIS_LSB      = 24;
   // interrupt status layout
   localparam int          IRQ_W            = 3;
   localparam int          IRQ_SEC_TMO      = 0;
   localparam int          IRQ_PRI_TMO      = 1;
   localparam int          IRQ_RETRY_TMO    = 2;
   // side index
   localparam int          SIDE_SEC         = 0;
   localparam int          SIDE_PRI         = 1;
endpackage

// File: core/bpt_timeout_counter.sv
// one master timeout down-counter with discard pulse
`timescale 1ns/100ps
`default_nettype none
module bpt_timeout_counter
   import bpt_pkg::*;
(
   input  wire logic             i_clock,
   input  wire logic             i_arst_n,
   input  wire logic [TMO_W-1:0] i_init,
   input  wire logic             i_start,
   input  wire logic             i_stop,
   output logic                  o_running,
   output logic                  o_expire
);
   logic [TMO_W-1:0] count_r;
   logic             run_r;
   logic             expire_r;

   //////////////////////////////////////////////////////////////////////
   // retrieval wins over a start in the same cycle
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         count_r <= '0;
         run_r   <= 1'b0;
      end else if (i_stop) begin
         run_r   <= 1'b0;
      end else if (i_start) begin
         count_r <= i_init;
         run_r   <= 1'b1;
      end else if (run_r) begin
         if (count_r <= 16'h0001) begin
            run_r   <= 1'b0;
         end
         count_r <= (count_r == '0) ? '0 : count_r - 16'h0001;
      end
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         expire_r <= 1'b0;
      end else begin
         expire_r <= run_r & ~i_stop & (count_r <= 16'h0001);
      end
   end

   assign o_running = run_r;
   assign o_expire  = expire_r;
endmodule
`default_nettype wire

// File: tb/bpt_bridge_option_regs_monitor.sv
// bound checker for the port option and timeout register block
`timescale 1ns/100ps
`default_nettype none
module bpt_bridge_option_regs_monitor
   import bpt_pkg::*;
(
   input wire logic              i_clock,
   input wire logic              i_arst_n,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic              i_wr,
   input wire logic              i_rd,
   input wire logic [DATA_W-1:0] o_rdata,
   input wire logic              i_sec_write_and_invalidate_cmd,
   input wire logic              i_sec_line_boundary,
   input wire logic              o_sec_plain_memory_write_cmd,
   input wire logic              o_sec_wi_disconnect,
   input wire logic              i_lock_active,
   input wire logic              o_lock_long_req,
   input wire logic              i_sec_frame,
   input wire logic              o_sec_req,
   input wire logic              i_pri_frame,
   input wire logic              o_pri_req,
   input wire logic              o_sec_discard
);
   logic [3:0] po_r;
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_arst_n);
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         po_r <= PO_UPPER_RST;
      end else if (i_wr && i_addr == OFF_PORT_OPTION) begin
         po_r <= i_wdata[11:8];
      end
   end
   ////////////////////////////////////////////////////////////////////////
   property p_wi_plain;
      i_sec_write_and_invalidate_cmd && !po_r[0]
         |=> o_sec_plain_memory_write_cmd;
   endproperty
   a_wi_plain: assert property (p_wi_plain)
      else $error("wi command not passed as plain write");
   property p_wi_disc;
      o_sec_wi_disconnect |-> $past(i_sec_write_and_invalidate_cmd
         && i_sec_line_boundary && po_r[0]);
   endproperty
   a_wi_disc: assert property (p_wi_disc)
      else $error("disconnect without cause");
   property p_long;
      i_lock_active && po_r[1] |=> o_lock_long_req;
   endproperty
   a_long: assert property (p_long)
      else $error("long request missing in lock");
   property p_sec_drop;
      i_sec_frame && !po_r[2] |=> !o_sec_req;
   endproperty
   a_sec_drop: assert property (p_sec_drop)
      else $error("sec request held after frame");
   property p_pri_drop;
      i_pri_frame && !po_r[3] |=> !o_pri_req;
   endproperty
   a_pri_drop: assert property (p_pri_drop)
      else $error("pri request held after frame");
   property p_po_rd;
      i_rd && i_addr == OFF_PORT_OPTION
         |=> o_rdata[15:8] == {4'h0, $past(po_r)};
   endproperty
   a_po_rd: assert property (p_po_rd)
      else $error("port option read wrong");
   property p_slot;
      i_rd && i_addr == OFF_SLOT_IDENT |=> o_rdata[7:0] == 8'h04;
   endproperty
   a_slot: assert property (p_slot)
      else $error("slot capability code wrong");
   property p_disc;
      o_sec_discard |=> !o_sec_discard;
   endproperty
   a_disc: assert property (p_disc)
      else $error("discard longer than one cycle");
   property p_rd_idle;
      !i_rd |=> o_rdata == 32'h0000_0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data outside read cycle");
endmodule
bind bpt_bridge_option_regs bpt_bridge_option_regs_monitor u_mon (
   .i_clock(i_clock), .i_arst_n(i_arst_n), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .i_sec_write_and_invalidate_cmd(i_sec_write_and_invalidate_cmd),
   .i_sec_line_boundary(i_sec_line_boundary),
   .o_sec_plain_memory_write_cmd(o_sec_plain_memory_write_cmd),
   .o_sec_wi_disconnect(o_sec_wi_disconnect),
   .i_lock_active(i_lock_active), .o_lock_long_req(o_lock_long_req),
   .i_sec_frame(i_sec_frame), .o_sec_req(o_sec_req),
   .i_pri_frame(i_pri_frame), .o_pri_req(o_pri_req),
   .o_sec_discard(o_sec_discard)
);
`default_nettype wire

// File: tb/bpt_bridge_option_regs_tb_top.sv
// testbench for the port option and timeout register block
`timescale 1ns/100ps
`default_nettype none
module bpt_bridge_option_regs_tb_top
   import bpt_pkg::*;
;
   logic        clk, rst_n, wr, rd, wi, bnd, plain, disc, lock, lreq;
   logic        rtry, rsucc, rto, irq;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata;
   logic [1:0]  want, pend, frm, done, req, rshort, rlast, rfirst, rret, dsc;
   int          error_cnt, compares, n, b, s;
   bpt_bridge_option_regs u_bpt_bridge_option_regs (
      .i_clock(clk), .i_arst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .i_sec_write_and_invalidate_cmd(wi), .i_sec_line_boundary(bnd),
      .o_sec_plain_memory_write_cmd(plain), .o_sec_wi_disconnect(disc),
      .i_lock_active(lock), .o_lock_long_req(lreq),
      .i_sec_queue_pending(pend[0]), .i_sec_frame(frm[0]),
      .i_sec_target_term(1'b0), .i_sec_xfer_done(done[0]), .o_sec_req(req[0]),
      .i_pri_queue_pending(pend[1]), .i_pri_frame(frm[1]),
      .i_pri_target_term(1'b0), .i_pri_xfer_done(done[1]), .o_pri_req(req[1]),
      .i_sec_rd_short(rshort[0]), .i_sec_rd_last_data(rlast[0]),
      .i_sec_rd_first_line(rfirst[0]), .i_sec_rd_retrieved(rret[0]),
      .o_sec_discard(dsc[0]), .i_pri_rd_short(rshort[1]),
      .i_pri_rd_last_data(rlast[1]), .i_pri_rd_first_line(rfirst[1]),
      .i_pri_rd_retrieved(rret[1]), .o_pri_discard(dsc[1]),
      .i_retry_attempt(rtry), .i_retry_success(rsucc),
      .o_retry_timeout(rto), .o_irq(irq));
   bpt_pci_side u_side_sec (.i_clock(clk), .i_arst_n(rst_n), .i_req(req[0]),
      .i_want(want[0]), .o_pending(pend[0]), .o_frame(frm[0]),
      .o_done(done[0]));
   bpt_pci_side u_side_pri (.i_clock(clk), .i_arst_n(rst_n), .i_req(req[1]),
      .i_want(want[1]), .o_pending(pend[1]), .o_frame(frm[1]),
      .o_done(done[1]));
   always #2.5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////
   task automatic stop_test;
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1 chk(rdata, e);
   endtask
   // start a timer, count cycles to discard
   task automatic tmo(input int sd, input logic sh, input int e);
      @(posedge clk);
      rshort[sd] <= sh;
      rlast[sd]  <= sh;
      rfirst[sd] <= !sh;
      @(posedge clk);
      rlast  <= 2'b00;
      rfirst <= 2'b00;
      n = 0;
      do begin
         @(posedge clk);
         #1 n++;
      end while (dsc[sd] !== 1'b1 && n < 2000);
      chk(n, e);
      if (n >= 2000) stop_test();
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {clk, rst_n, wr, rd, wi, bnd, lock, rtry, rsucc} = '0;
      {addr, wdata, want, rshort, rlast, rfirst, rret} = '0;
      error_cnt = 0;
      compares  = 0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      rd_reg(OFF_PORT_OPTION, 32'h0000_0c00);
      rd_reg(OFF_RETRY_LIMIT, 32'h0100_0000);
      rd_reg(OFF_MASTER_TMO, 32'h8000_8000);
      rd_reg(OFF_SLOT_IDENT, 32'h0000_0004);
      rd_reg(8'h10, 32'h0000_0000);
      wr_reg(OFF_PORT_OPTION, 32'hffff_ffff);
      rd_reg(OFF_PORT_OPTION, 32'h0000_0f00);
      wr_reg(OFF_SLOT_IDENT, 32'hffff_ffff);
      rd_reg(OFF_SLOT_IDENT, 32'hff3f_0004);
      for (b = 0; b < 2; b++) begin
         wr_reg(OFF_PORT_OPTION, b ? 32'h0000_0300 : 32'h0000_0000);
         @(posedge clk);
         {wi, bnd, lock} <= 3'b111;
         @(posedge clk);
         {wi, bnd, lock} <= 3'b000;
         #1 chk({plain, disc, lreq}, b ? 3'b011 : 3'b100);
      end
      // request hold per side
      for (b = 0; b < 2; b++) begin
         wr_reg(OFF_PORT_OPTION, b ? 32'h0000_0c00 : 32'h0000_0000);
         @(posedge clk);
         want <= 2'b11;
         for (s = 0; s < 2; s++) begin
            n = 0;
            do begin
               @(posedge clk);
               #1 n++;
            end while (frm[s] !== 1'b1 && n < 50);
            if (n >= 50) begin
               error_cnt++;
               stop_test();
            end
            repeat (2) @(posedge clk);
            #1 chk(req[s], b);
         end
         @(posedge clk);
         want <= 2'b00;
         repeat (8) @(posedge clk);
      end
      // fine timeouts and interrupt
      wr_reg(OFF_IRQ_ENABLE, 32'h0000_0007);
      wr_reg(OFF_MASTER_TMO, 32'h0003_0002);
      tmo(0, 1'b1, 2);
      tmo(1, 1'b0, 3);
      @(posedge clk);
      #1 chk(irq, 1'b1);
      wr_reg(OFF_IRQ_ENABLE, 32'h0000_0000);
      rd_reg(OFF_IRQ_STATUS, 32'h0000_0003);
      chk(irq, 1'b0);
      wr_reg(OFF_IRQ_CLEAR, 32'h0000_0003);
      wr_reg(OFF_IRQ_ENABLE, 32'h0000_0007);
      rd_reg(OFF_IRQ_STATUS, 32'h0000_0000);
      chk(irq, 1'b0);
      // retrieval stops the timer
      @(posedge clk);
      {rshort[0], rlast[0]} <= 2'b11;
      @(posedge clk);
      rlast[0] <= 1'b0;
      rret[0]  <= 1'b1;
      @(posedge clk);
      rret[0]  <= 1'b0;
      repeat (8) @(posedge clk);
      #1 chk(dsc[0], 1'b0);
      // last write wins
      wr_reg(OFF_COARSE_CTRL, 32'h0000_0000);
      tmo(0, 1'b1, 1024);
      wr_reg(OFF_MASTER_TMO, 32'h0005_0005);
      tmo(1, 1'b1, 5);
      // success restarts retry count
      wr_reg(OFF_RETRY_LIMIT, 32'h0000_0003);
      @(posedge clk);
      rtry <= 1'b1;
      repeat (2) @(posedge clk);
      {rtry, rsucc} <= 2'b01;
      @(posedge clk);
      {rtry, rsucc} <= 2'b10;
      repeat (2) @(posedge clk);
      #1 chk(rto, 1'b0);
      @(posedge clk);
      rtry <= 1'b0;
      #1 chk(rto, 1'b1);
      stop_test();
   end
   initial begin
      #500000;
      error_cnt++;
      stop_test();
   end
endmodule
`default_nettype wire

// File: tb/bpt_pci_side.sv
// far-side bus agent model
`timescale 1ns/100ps
`default_nettype none
module bpt_pci_side (
   input  wire logic i_clock,
   input  wire logic i_arst_n,
   input  wire logic i_req,
   input  wire logic i_want,
   output logic      o_pending,
   output logic      o_frame,
   output logic      o_done
);
   logic [2:0] busy_r;
   assign o_pending = i_want;
   // four-cycle transfer per grant
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         busy_r  <= 3'd0;
         o_frame <= 1'b0;
         o_done  <= 1'b0;
      end else begin
         o_frame <= (busy_r == 3'd0) && i_req && !o_frame;
         o_done  <= (busy_r == 3'd1);
         if (busy_r == 3'd0 && i_req && !o_frame) begin
            busy_r <= 3'd4;
         end else if (busy_r != 3'd0) begin
            busy_r <= busy_r - 3'd1;
         end
      end
   end
endmodule
`default_nettype wire
